// ### rtl/ext_irq_pkg.sv
// constants for the external interrupt input block: register indices,
// field positions, reset values and timing counts.
// assumes the core clock hclk also stands for the oscillator clock fc.
package ext_irq_pkg;

  // clock rates; fc defaults to the core clock rate
  localparam longint unsigned CLK_HZ           = 100_000_000;
  localparam longint unsigned OSC_HZ           = 100_000_000;

  // times in oscillator periods (1/fc)
  localparam longint unsigned NOISE_REJECT_FC  = 7;
  localparam longint unsigned NOISE_ACCEPT_FC  = 24;
  localparam longint unsigned MACHINE_CYCLE_FC = 4;
  localparam longint unsigned LATCH_MAX_FC     = 25;

  // least stable width in clock cycles, rounded up
  localparam int unsigned NOISE_CYCLES =
    int'((NOISE_REJECT_FC * CLK_HZ + OSC_HZ - 64'h1) / OSC_HZ);
  // edges ignored after reset until sync and filter have settled
  localparam int unsigned SETTLE_CYCLES = NOISE_CYCLES + 3;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'h37;
  localparam logic [7:0] IDX_STATUS  = 8'h38;
  localparam logic [7:0] IDX_ENABLE  = 8'h39;
  localparam logic [7:0] IDX_MODE    = 8'h3A;
  localparam logic [7:0] IDX_PORT    = 8'h3B;

  // ext_irq_control fields
  localparam int unsigned CTRL_B_EDGE_BIT   = 2;
  localparam int unsigned CTRL_TC3_EDGE_BIT = 3;
  localparam int unsigned CTRL_D_EDGE_BIT   = 4;
  localparam int unsigned CTRL_TC4_EDGE_BIT = 5;
  localparam int unsigned CTRL_PIN_SEL_BIT  = 6;
  localparam logic [7:0]  CTRL_WMASK        = 8'h7C;
  localparam logic [7:0]  CTRL_RESET        = 8'h00;

  // mode register fields
  localparam int unsigned MODE_MASTER_BIT   = 0;
  localparam int unsigned MODE_STOP_HIZ_BIT = 1;
  localparam logic [1:0]  MODE_RESET        = 2'h0;

  // port register fields
  localparam int unsigned PORT_OUT_BIT      = 0;
  localparam int unsigned PORT_DIR_BIT      = 1;
  localparam int unsigned PORT_LEVEL_LSB    = 4;
  localparam logic        PORT_OUT_RESET    = 1'h1;
  localparam logic        PORT_DIR_RESET    = 1'h0;

  // sources, one bit each in status and enable
  localparam int unsigned NUM_SRC = 5;
  localparam int unsigned SRC_A   = 0;
  localparam int unsigned SRC_B   = 1;
  localparam int unsigned SRC_C   = 2;
  localparam int unsigned SRC_D   = 3;
  localparam int unsigned SRC_E   = 4;
  localparam logic [4:0]  ENABLE_RESET = 5'h00;

  // edge choice for ext_irq_c, from the remote-control preprocessor
  localparam logic [1:0] C_EDGE_FALL = 2'h0;
  localparam logic [1:0] C_EDGE_RISE = 2'h1;

  // AHB-Lite
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'h0;

endpackage : ext_irq_pkg

// ### rtl/external_interrupt_inputs.sv
// external interrupt inputs: five pins conditioned into request latches,
// reached over AHB-Lite, with the shared port pin of the first input.
// assumes an AHB-Lite master on hclk; pins are asynchronous.
//
// How it works
// - after reset the shared first pin is a port input, not an interrupt
// - with pin select 0, a falling edge on pin a sets no latch
// - pin select 0 gives port I/O, 1 the interrupt; latch kept 1 by software
// - edge select for b and d: 0 rising, 1 falling, in the control register
// - b and d reject pulses under 7/fc, accept 24/fc or longer
// - the timer event input shares the b filter
// - c takes falling, rising or both edges as the preprocessor selects
// - b to e serviced only with master enable and own enable set
// - clean edges on b and d set their latch within 25/fc
// - stop with hi-z forces a to d low at the edge logic, not in the port read; may set latches except e
// - a latch holds until accepted, written clear, or reset
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module external_interrupt_inputs (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        shared_port_pin,
  input  wire logic        ext_irq_b,
  input  wire logic        ext_irq_c,
  input  wire logic        ext_irq_d,
  input  wire logic        ext_irq_e,
  output logic             shared_port_pin_out,
  output logic             shared_port_pin_oe,
  input  wire logic [1:0]  c_edge_mode,
  input  wire logic [4:0]  irq_accept,
  output logic             timer_event_input,
  output logic [4:0]       irq_request_latch,
  output logic [4:0]       irq_service,
  output logic             irq
);

  localparam int unsigned N  = ext_irq_pkg::NUM_SRC;
  localparam int unsigned SW = $clog2(ext_irq_pkg::SETTLE_CYCLES + 1);
  localparam logic [SW-1:0] SETTLE_LAST = SW'(ext_irq_pkg::SETTLE_CYCLES);

  typedef struct packed {
    logic [7:0]    control;
    logic [N-1:0]  enable;
    logic [N-1:0]  status;
    logic          master;
    logic          stop_hiz;
    logic          port_out;
    logic          port_dir;
    logic [N-1:0]  prev;
    logic [SW-1:0] settle;
    logic          wr_pend;
    logic [7:0]    wr_idx;
    logic [31:0]   rdata;
    logic          ready;
    logic          resp;
    logic          pin_out;
    logic          pin_oe;
    logic          timer_evt;
    logic [N-1:0]  service;
    logic          irq;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  logic [N-1:0] pin_raw;
  logic [N-1:0] pin_sync_lvl;
  logic [N-1:0] pin_in;
  logic [N-1:0] pin_clean;

  assign pin_raw = {ext_irq_e, ext_irq_d, ext_irq_c, ext_irq_b, shared_port_pin};

  pin_sync #(
    .WIDTH (N)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (pin_raw),
    .dout    (pin_sync_lvl)
  );

  // in stop with hi-z outputs the edge logic sees the port inputs low, the port level read does not; e has no port role
  always_comb begin
    pin_in = pin_sync_lvl;
    if (st_r.stop_hiz) begin
      pin_in = pin_sync_lvl & (N'(1) << ext_irq_pkg::SRC_E);
    end
  end

  // a and e rely on their hysteresis and a width of over one machine cycle
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_src
      if (g == ext_irq_pkg::SRC_B || g == ext_irq_pkg::SRC_D) begin : g_filt
        noise_filter #(
          .STABLE (ext_irq_pkg::NOISE_CYCLES)
        ) u_filt (
          .hclk    (hclk),
          .hresetn (hresetn),
          .din     (pin_in[g]),
          .dout    (pin_clean[g])
        );
      end else begin : g_pass
        assign pin_clean[g] = pin_in[g];
      end
    end
  endgenerate

  logic [N-1:0]  rise;
  logic [N-1:0]  fall;
  logic [N-1:0]  set;
  logic [N-1:0]  clr;
  logic [N-1:0]  gate;
  logic          pin_sel;
  logic          addr_ok;
  logic          take;
  logic [7:0]    wdata;
  logic [31:0]   rd;

  function automatic logic [31:0] reg_read(input state_type s, input logic [7:0] idx,
                                           input logic [N-1:0] lvl);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (idx == ext_irq_pkg::IDX_CONTROL) begin
      v[7:0] = s.control & ext_irq_pkg::CTRL_WMASK;
    end else if (idx == ext_irq_pkg::IDX_STATUS) begin
      v[N-1:0] = s.status;
    end else if (idx == ext_irq_pkg::IDX_ENABLE) begin
      v[N-1:0] = s.enable;
    end else if (idx == ext_irq_pkg::IDX_MODE) begin
      v[ext_irq_pkg::MODE_MASTER_BIT]   = s.master;
      v[ext_irq_pkg::MODE_STOP_HIZ_BIT] = s.stop_hiz;
    end else if (idx == ext_irq_pkg::IDX_PORT) begin
      v[ext_irq_pkg::PORT_OUT_BIT] = s.port_out;
      v[ext_irq_pkg::PORT_DIR_BIT] = s.port_dir;
      v[ext_irq_pkg::PORT_LEVEL_LSB +: N] = lvl;
    end
    return v;
  endfunction : reg_read

  always_comb begin
    st_nxt  = st_r;
    pin_sel = st_r.control[ext_irq_pkg::CTRL_PIN_SEL_BIT];
    wdata   = hwdata[7:0];

    // edge detection on conditioned levels; settle window masks reset ramp
    rise = pin_clean & ~st_r.prev;
    fall = ~pin_clean & st_r.prev;
    st_nxt.prev = pin_clean;
    if (st_r.settle != SETTLE_LAST) begin
      st_nxt.settle = st_r.settle + SW'(1);
      rise = '0;
      fall = '0;
    end

    set = '0;
    set[ext_irq_pkg::SRC_A] = fall[ext_irq_pkg::SRC_A] & pin_sel;
    if (st_r.control[ext_irq_pkg::CTRL_B_EDGE_BIT]) begin
      set[ext_irq_pkg::SRC_B] = fall[ext_irq_pkg::SRC_B];
    end else begin
      set[ext_irq_pkg::SRC_B] = rise[ext_irq_pkg::SRC_B];
    end
    if (st_r.control[ext_irq_pkg::CTRL_D_EDGE_BIT]) begin
      set[ext_irq_pkg::SRC_D] = fall[ext_irq_pkg::SRC_D];
    end else begin
      set[ext_irq_pkg::SRC_D] = rise[ext_irq_pkg::SRC_D];
    end
    if (c_edge_mode == ext_irq_pkg::C_EDGE_FALL) begin
      set[ext_irq_pkg::SRC_C] = fall[ext_irq_pkg::SRC_C];
    end else if (c_edge_mode == ext_irq_pkg::C_EDGE_RISE) begin
      set[ext_irq_pkg::SRC_C] = rise[ext_irq_pkg::SRC_C];
    end else begin
      set[ext_irq_pkg::SRC_C] = rise[ext_irq_pkg::SRC_C] | fall[ext_irq_pkg::SRC_C];
    end
    set[ext_irq_pkg::SRC_E] = fall[ext_irq_pkg::SRC_E];

    // address phase: decode and capture; reads answer in the data phase
    addr_ok = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
    take    = hsel && hready && htrans[1];
    st_nxt.wr_pend = 1'b0;
    if (take) begin
      st_nxt.wr_pend = hwrite && addr_ok && (hsize == ext_irq_pkg::HSIZE_WORD);
      st_nxt.wr_idx  = haddr[9:2];
    end

    // data phase write; software owns the ordering around master enable
    clr = irq_accept;
    if (st_r.wr_pend) begin
      if (st_r.wr_idx == ext_irq_pkg::IDX_CONTROL) begin
        st_nxt.control = wdata & ext_irq_pkg::CTRL_WMASK;
      end else if (st_r.wr_idx == ext_irq_pkg::IDX_STATUS) begin
        clr = clr | wdata[N-1:0];
      end else if (st_r.wr_idx == ext_irq_pkg::IDX_ENABLE) begin
        st_nxt.enable = wdata[N-1:0];
      end else if (st_r.wr_idx == ext_irq_pkg::IDX_MODE) begin
        st_nxt.master   = wdata[ext_irq_pkg::MODE_MASTER_BIT];
        st_nxt.stop_hiz = wdata[ext_irq_pkg::MODE_STOP_HIZ_BIT];
      end else if (st_r.wr_idx == ext_irq_pkg::IDX_PORT) begin
        st_nxt.port_out = wdata[ext_irq_pkg::PORT_OUT_BIT];
        st_nxt.port_dir = wdata[ext_irq_pkg::PORT_DIR_BIT];
      end
    end

    // a new edge wins over a clear in the same cycle
    st_nxt.status = (st_r.status & ~clr) | set;

    rd = 32'h0000_0000;
    if (take && !hwrite && addr_ok) begin
      rd = reg_read(st_nxt, haddr[9:2], pin_sync_lvl);
    end
    if (take) begin
      st_nxt.rdata = rd;
    end
    st_nxt.ready = 1'b1;
    st_nxt.resp  = ext_irq_pkg::HRESP_OKAY;

    // port drive: latch value out, released while stopped with hi-z outputs
    st_nxt.pin_out = st_nxt.port_out;
    st_nxt.pin_oe  = st_nxt.port_dir & ~st_nxt.stop_hiz;

    st_nxt.timer_evt = pin_clean[ext_irq_pkg::SRC_B];

    // a needs the pin function; all need master and their own enable
    gate = '1;
    gate[ext_irq_pkg::SRC_A] = st_nxt.control[ext_irq_pkg::CTRL_PIN_SEL_BIT];
    if (st_nxt.master) begin
      st_nxt.service = st_nxt.status & st_nxt.enable & gate;
    end else begin
      st_nxt.service = '0;
    end
    st_nxt.irq = |st_nxt.service;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r          <= '0;
      st_r.control  <= ext_irq_pkg::CTRL_RESET;
      st_r.enable   <= ext_irq_pkg::ENABLE_RESET;
      st_r.master   <= ext_irq_pkg::MODE_RESET[ext_irq_pkg::MODE_MASTER_BIT];
      st_r.stop_hiz <= ext_irq_pkg::MODE_RESET[ext_irq_pkg::MODE_STOP_HIZ_BIT];
      st_r.port_out <= ext_irq_pkg::PORT_OUT_RESET;
      st_r.port_dir <= ext_irq_pkg::PORT_DIR_RESET;
      st_r.pin_out  <= ext_irq_pkg::PORT_OUT_RESET;
      st_r.ready    <= 1'b1;
      st_r.resp     <= ext_irq_pkg::HRESP_OKAY;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata              = st_r.rdata;
  assign hreadyout           = st_r.ready;
  assign hresp               = st_r.resp;
  assign shared_port_pin_out = st_r.pin_out;
  assign shared_port_pin_oe  = st_r.pin_oe;
  assign timer_event_input   = st_r.timer_evt;
  assign irq_request_latch   = st_r.status;
  assign irq_service         = st_r.service;
  assign irq                 = st_r.irq;

endmodule : external_interrupt_inputs
`default_nettype wire

// ### rtl/noise_filter.sv
// digital noise rejection for one synchronised input.
// the output follows only after the input has differed for STABLE
// consecutive clocks; shorter pulses never show at the output.
`timescale 1ns/10ps
`default_nettype none
module noise_filter #(
  parameter int unsigned STABLE = ext_irq_pkg::NOISE_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic din,
  output logic      dout
);

  localparam int unsigned CW = $clog2(STABLE + 1);
  localparam logic [CW-1:0] LAST = CW'(STABLE - 1);

  typedef struct packed {
    logic          level;
    logic [CW-1:0] cnt;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (din == st_r.level) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt == LAST) begin
      st_nxt.level = din;
      st_nxt.cnt   = '0;
    end else begin
      st_nxt.cnt = st_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.level;

endmodule : noise_filter
`default_nettype wire

// ### rtl/pin_sync.sv
// two-flop synchroniser for a group of asynchronous pins.
// assumes each bit is an independent level; no word coherence.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 5
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = din;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.sync;

endmodule : pin_sync
`default_nettype wire

// ### verification/ext_irq_checker_assertions.sv
// port checker for external_interrupt_inputs, bound to the top module.
// assumes a single AHB-Lite master and word writes at aligned addresses.
`timescale 1ns/10ps
`default_nettype none
module ext_irq_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        ext_irq_b,
  input wire logic        shared_port_pin_out,
  input wire logic        shared_port_pin_oe,
  input wire logic [4:0]  irq_accept,
  input wire logic        timer_event_input,
  input wire logic [4:0]  irq_request_latch,
  input wire logic [4:0]  irq_service,
  input wire logic        irq
);
  logic            wr_pend_r;
  logic            sel_r;
  logic            mst_r;
  logic      [7:0] wr_idx_r;
  logic      [3:0] b_run_r;
  wire logic       wr_dp = wr_pend_r && hready;
  wire logic [4:0] clr_w = irq_accept |
                           ((wr_dp && wr_idx_r == ext_irq_pkg::IDX_STATUS) ? hwdata[4:0] : 5'h00);

  // shadow of the control and mode bits, updated at the end of the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
      sel_r     <= 1'b0;
      mst_r     <= 1'b0;
      b_run_r   <= 4'h0;
    end else begin
      b_run_r <= !ext_irq_b ? 4'h0 : (b_run_r == 4'hF ? b_run_r : b_run_r + 4'h1);
      if (wr_dp && wr_idx_r == ext_irq_pkg::IDX_CONTROL)
        sel_r <= hwdata[ext_irq_pkg::CTRL_PIN_SEL_BIT];
      if (wr_dp && wr_idx_r == ext_irq_pkg::IDX_MODE)
        mst_r <= hwdata[ext_irq_pkg::MODE_MASTER_BIT];
      if (hready) begin
        wr_pend_r <= hsel && htrans[1] && hwrite;
        wr_idx_r  <= haddr[9:2];
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence release_s;
    $rose(hresetn);
  endsequence
  sequence b_passed_s;
    $rose(timer_event_input);
  endsequence

  chk_zero_wait:
    assert property (hreadyout && hresp == ext_irq_pkg::HRESP_OKAY) else $error("bus stalled");
  chk_port_reset:
    assert property (release_s |-> shared_port_pin_out && !shared_port_pin_oe)
      else $error("shared pin not a port input after reset");
  chk_pin_a_gate:
    assert property ($rose(irq_request_latch[0]) |-> sel_r || $past(sel_r))
      else $error("latch a set while pin select is 0");
  chk_b_filter:
    assert property (b_passed_s |-> $past(b_run_r, 4) >= 4'h4)
      else $error("short pulse on b passed the filter");
  chk_service_src:
    assert property ((irq_service & ~irq_request_latch) == 5'h00)
      else $error("service without latch");
  chk_master_gate:
    assert property (|irq_service |-> mst_r || $past(mst_r)) else $error("service with master off");
  chk_irq_or:
    assert property (irq == |irq_service) else $error("irq not the or of service");
  chk_latch_hold:
    assert property (($past(irq_request_latch) & ~irq_request_latch & ~$past(clr_w)) == 5'h00)
      else $error("latch dropped without clear");
endmodule : ext_irq_checker

bind external_interrupt_inputs ext_irq_checker ext_irq_checker_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
  .ext_irq_b(ext_irq_b), .shared_port_pin_out(shared_port_pin_out),
  .shared_port_pin_oe(shared_port_pin_oe), .irq_accept(irq_accept),
  .timer_event_input(timer_event_input), .irq_request_latch(irq_request_latch),
  .irq_service(irq_service), .irq(irq));
`default_nettype wire

// ### verification/pin_source.sv
// off-chip sources on the five interrupt pins, a to e in bits 0 to 4.
// assumes the bench calls drive just after a rising edge of hclk.
`timescale 1ns/10ps
`default_nettype none
module pin_source (
  input  wire logic       hclk,
  output var  logic [4:0] lvl
);
  initial lvl = 5'h1F;

  // a and e are unfiltered, so a level shorter than 5 clocks is stretched
  task automatic drive(input int i, input logic v, input int hold);
    int n;
    n = ((i == 0 || i == 4) && hold < 5) ? 5 : hold;
    @(posedge hclk);
    lvl[i] <= v;
    // the next call's own edge ends this level, so it stands n clocks
    repeat (n - 1) @(posedge hclk);
  endtask : drive
endmodule : pin_source
`default_nettype wire

// ### verification/test_external_interrupt_inputs.sv
// self-checking bench for external_interrupt_inputs with a latch model.
// assumes zero-wait AHB-Lite and fc equal to hclk.
`timescale 1ns/10ps
`default_nettype none
module test_external_interrupt_inputs;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pin_out, pin_oe;
  logic        timer_ev, irq, sel, mst, eb, ed;
  logic [31:0] haddr, hwdata, hrdata, rd, r;
  logic [1:0]  htrans, c_edge_mode;
  logic [2:0]  hsize;
  logic [4:0]  irq_accept, latch, service, lvl, exp_lat, en;
  logic [7:0]  c;
  int          n_fail, n_compared, seed, i, s;
  wire logic   pin_a = pin_oe ? pin_out : lvl[0];

  external_interrupt_inputs external_interrupt_inputs_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .shared_port_pin(pin_a), .ext_irq_b(lvl[1]),
    .ext_irq_c(lvl[2]), .ext_irq_d(lvl[3]), .ext_irq_e(lvl[4]), .shared_port_pin_out(pin_out),
    .shared_port_pin_oe(pin_oe), .c_edge_mode(c_edge_mode), .irq_accept(irq_accept),
    .timer_event_input(timer_ev), .irq_request_latch(latch), .irq_service(service), .irq(irq));
  pin_source pin_source_i (.hclk(hclk), .lvl(lvl));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic report_and_stop;
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wait_ready;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && k < 20) begin
      k++;
      @(posedge hclk);
    end
    if (k >= 20) begin
      n_fail++;
      report_and_stop();
    end
  endtask : wait_ready

  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= w;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : bus

  function automatic logic fires(int k, logic o, logic n);
    case (k)
      0: return sel && o && !n;
      1: return eb ? o && !n : !o && n;
      2: return c_edge_mode == ext_irq_pkg::C_EDGE_FALL ? o && !n :
                c_edge_mode == ext_irq_pkg::C_EDGE_RISE ? !o && n : o != n;
      3: return ed ? o && !n : !o && n;
      default: return o && !n;
    endcase
  endfunction : fires

  task automatic compare;
    logic [4:0] srv;
    srv = exp_lat & en & {5{mst}} & {4'hF, sel};
    check({27'h0, latch}, {27'h0, exp_lat});
    check({27'h0, service}, {27'h0, srv});
    check({31'h0, irq}, {31'h0, |srv});
    check({31'h0, timer_ev}, {31'h0, lvl[1]});
  endtask : compare

  // short pulses go out and back on b or d and must leave no trace
  task automatic step(input int k, input int h);
    logic o;
    o = lvl[k];
    if (h < 24 && (k == 1 || k == 3)) begin
      pin_source_i.drive(k, !o, h);
      pin_source_i.drive(k, o, 30);
    end else begin
      exp_lat[k] = exp_lat[k] | fires(k, o, !o);
      pin_source_i.drive(k, !o, 26);
    end
    compare();
  endtask : step

  task automatic clear(input logic [4:0] m, input logic acc);
    if (acc) begin
      irq_accept <= m;
      @(posedge hclk);
      irq_accept <= 5'h00;
      @(posedge hclk);
    end else
      bus(1'b1, ext_irq_pkg::IDX_STATUS, {27'h0, m});
    exp_lat = exp_lat & ~m;
    bus(1'b0, ext_irq_pkg::IDX_STATUS, 32'h0);
    check(rd, {27'h0, exp_lat});
  endtask : clear

  task automatic configure(input logic [7:0] cv, input logic [4:0] e, input logic m);
    bus(1'b1, ext_irq_pkg::IDX_MODE, 32'h0);
    bus(1'b1, ext_irq_pkg::IDX_CONTROL, {24'h0, cv});
    sel = cv[6];
    eb  = cv[2];
    ed  = cv[4];
    bus(1'b0, ext_irq_pkg::IDX_CONTROL, 32'h0);
    check(rd, {24'h0, cv & ext_irq_pkg::CTRL_WMASK});
    clear(5'h1F, 1'b0);
    en  = e;
    mst = m;
    bus(1'b1, ext_irq_pkg::IDX_ENABLE, {27'h0, e});
    bus(1'b1, ext_irq_pkg::IDX_MODE, {31'h0, m});
  endtask : configure

  initial begin
    seed = 32'h8eb6;
    {hresetn, hsel, hwrite, sel, mst, eb, ed} = 7'h00;
    {haddr, hwdata, htrans, c_edge_mode, irq_accept, exp_lat, en} = '0;
    hsize = ext_irq_pkg::HSIZE_WORD;
    n_fail = 0;
    n_compared = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    check({30'h0, pin_oe, pin_out}, 32'h1);
    repeat (12) @(posedge hclk);
    for (i = 0; i < 6; i++) begin
      bus(1'b0, ext_irq_pkg::IDX_CONTROL + i[7:0], 32'h0);
      check(rd, i == 4 ? 32'h1F1 : 32'h0);
    end
    step(0, 26);
    step(0, 26);
    for (i = 0; i < 60; i++) begin
      r = $random(seed);
      if (i % 10 == 0) begin
        c = r[7:0];
        c[6] = (i != 30);
        c[2] = 1'(i / 10 % 2);
        c[4] = 1'(i / 20 % 2);
        c_edge_mode <= 2'(i / 10 % 3);
        configure(c, r[12:8], r[13]);
      end
      r = $random(seed);
      s = int'(r[15:0] % 16'd5);
      step(s, r[16] ? 6 : 26);
      if (r[17])
        clear(r[22:18], r[23]);
    end
    c_edge_mode <= ext_irq_pkg::C_EDGE_FALL;
    configure(8'h54, 5'h1F, 1'b0);
    for (i = 0; i < 5; i++)
      if (!lvl[i])
        step(i, 26);
    clear(5'h1F, 1'b0);
    bus(1'b1, ext_irq_pkg::IDX_PORT, 32'h3);
    @(posedge hclk);
    check({31'h0, pin_oe}, 32'h1);
    bus(1'b1, ext_irq_pkg::IDX_MODE, 32'h2);
    @(posedge hclk);
    check({31'h0, pin_oe}, 32'h0);
    repeat (26) @(posedge hclk);
    check({27'h0, latch}, 32'h0F);
    bus(1'b1, ext_irq_pkg::IDX_MODE, 32'h0);
    bus(1'b1, ext_irq_pkg::IDX_PORT, 32'h1);
    repeat (26) @(posedge hclk);
    check({27'h0, latch}, 32'h0F);
    exp_lat = 5'h0F;
    clear(5'h1F, 1'b0);
    report_and_stop();
  end
endmodule : test_external_interrupt_inputs
`default_nettype wire
